/* shared/icd_link_if.sv */
// Purpose: Two-wire link between controller and converter port.
// Assumes: Both lines pulled up; an enable pulls its line low.
// Notes: Out signals stay low, drivers are open drain.
`timescale 1ns/1ps
interface icd_link_if;
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up
	assign scl = !(hostSclOe && !hostSclOut);
	assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

	modport device (
		input  scl,
		input  sda,
		output devSdaOut,
		output devSdaOe
	);
	modport host (
		input  scl,
		input  sda,
		output hostSclOut,
		output hostSclOe,
		output hostSdaOut,
		output hostSdaOe
	);
endinterface

/* shared/icd_pkg.sv */
// Purpose: Shared constants for the current-sink converter serial port.
// Assumes: 250 MHz ref_clk, bus clock up to 400 kHz.
// Notes: Host register map is the controller's own.
package icd_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 4;
	localparam int SCL_PERIOD_NS   = 2500;
	// Least quarter period, rounded up to whole cycles
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
	                                 / (4 * CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Serial framing and device register layout
	// ------------------------------------------------------------
	localparam logic [4:0]  ADDR_PREFIX  = 5'h03;
	localparam logic [6:0]  ADDR_DEFAULT = 7'h0C;
	localparam logic [2:0]  BIT_LAST     = 3'h7;
	localparam logic [3:0]  BIT_ACK      = 4'h8;
	localparam logic [1:0]  LAST_BYTE    = 2'h2;
	localparam int          PWR_BIT      = 15;
	localparam int          CODE_MSB     = 13;
	localparam int          CODE_LSB     = 4;
	localparam int          CODE_W       = CODE_MSB - CODE_LSB + 1;
	localparam logic [15:0] INREG_RESET  = 16'h0000;

	// ------------------------------------------------------------
	// Host register map
	// ------------------------------------------------------------
	localparam int          AXI_AW       = 5;
	localparam logic [4:0]  REG_CTRL     = 5'h00;
	localparam logic [4:0]  REG_SLAVE    = 5'h04;
	localparam logic [4:0]  REG_WDATA    = 5'h08;
	localparam logic [4:0]  REG_RDATA    = 5'h0C;
	localparam logic [4:0]  REG_STATUS   = 5'h10;
	localparam int          CTRL_WR_BIT  = 0;
	localparam int          CTRL_RD_BIT  = 1;
	localparam int          STAT_DONE    = 0;
	localparam int          STAT_NACK    = 1;
	localparam int          STAT_BUSY    = 2;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* tb/icd_link_chk.sv */
// Purpose: Link assertions for the controller and converter port pair.
// Assumes: Both lines are sampled on ref_clk.
// Notes: Rise count restarts at every start condition.
`timescale 1ns/1ps
module icd_link_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hostSclOut,
	input wire logic hostSclOe,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	logic       sclD_q;
	logic       sdaD_q;
	logic [4:0] cnt_q;
	logic [7:0] sh_q;
	logic       rise;
	logic       strt;
	logic       hit;

	assign rise = scl && !sclD_q;
	assign strt = scl && sclD_q && sdaD_q && !sda;
	assign hit  = sh_q[7:3] == 5'h03;

	always_ff @(posedge ref_clk) begin
		sclD_q <= rst | scl;
		sdaD_q <= rst | sda;
	end
	always_ff @(posedge ref_clk) begin
		if (rst || strt) begin
			cnt_q <= 5'h00;
		end else if (rise && cnt_q != 5'h1F) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// Shift stops after the address byte so sh_q keeps it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sh_q <= 8'h00;
		end else if (rise && cnt_q < 5'h08) begin
			sh_q <= {sh_q[6:0], sda};
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_open_drain: assert property (!devSdaOut && !hostSdaOut && !hostSclOut)
		else $error("line driven high");
	a_addr_ack: assert property (rise && cnt_q == 5'h08 && hit |-> devSdaOe)
		else $error("address not acknowledged");
	a_addr_quiet: assert property (cnt_q >= 5'h08 && !hit |-> !devSdaOe)
		else $error("foreign address answered");
	a_addr_phase: assert property (cnt_q < 5'h08 |-> !devSdaOe)
		else $error("device drove during address");
	a_wr_ack: assert property (
		rise && hit && !sh_q[0] && (cnt_q == 5'h11 || cnt_q == 5'h1A) |-> devSdaOe)
		else $error("write byte not acknowledged");
	a_rd_release: assert property (
		rise && hit && sh_q[0] && (cnt_q == 5'h11 || cnt_q == 5'h1A) |-> !devSdaOe)
		else $error("master ack slot blocked");
	a_clk_low_move: assert property ($changed(devSdaOe) |-> !scl && !$past(scl))
		else $error("device moved data with clock high");
	a_reset_idle: assert property ($past(rst) |-> !devSdaOe && !hostSdaOe && !hostSclOe)
		else $error("line held after reset");
endmodule

/* tb/tb_top.sv */
// Purpose: Controller and converter port joined over the link.
// Assumes: Quarter period shortened to 8 cycles.
// Notes: Read results and loads are compared by watcher processes.
`timescale 1ns/1ps
module tb_top;
	import icd_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        pinN = 1'b1;
	logic [4:0]  awAddr = 5'h00;
	logic [4:0]  arAddr = 5'h00;
	logic [31:0] wData = 32'h0;
	logic        awValid = 1'b0;
	logic        wValid = 1'b0;
	logic        bReady = 1'b0;
	logic        arValid = 1'b0;
	logic        rReady = 1'b0;
	logic        rdChk = 1'b0;
	logic        awReady, wReady, bValid, arReady, rValid, top, pwrDn, dacPulse;
	logic [1:0]  rResp;
	logic [1:0]  bResp;
	logic        addr, clrPulse;
	logic [1:0]  bQ[$];
	int          addrCnt = 0;
	int          clrCnt = 0;
	int          mark;
	logic [31:0] rData, d, seed;
	logic [9:0]  code;
	logic [15:0] inReg, w;
	logic [33:0] rdQ[$];
	logic [10:0] dacQ[$];
	int          bad_count = 0;
	int          total_checks = 0;
	int          i;

	always #2 ref_clk = ~ref_clk;
	icd_link_if link ();
	icd_host #(.QUARTER_CYC(8)) i_icd_host (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .link(link.host));
	icd_device i_icd_device (.ref_clk(ref_clk), .rst(rst), .link(link.device),
		.powerOffControlN(pinN), .converterCodeBits(code), .inputBitTop(top),
		.inputRegValue(inReg), .powerDown(pwrDn), .addressed(addr), .dacLoadPulse(dacPulse),
		.readClearPulse(clrPulse));
	icd_link_chk i_icd_link_chk (.ref_clk(ref_clk), .rst(rst), .hostSclOut(link.hostSclOut),
		.hostSclOe(link.hostSclOe), .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe),
		.devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .scl(link.scl), .sda(link.sda));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		give_verdict();
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		int n;
		@(posedge ref_clk);
		// Unmapped or unaligned offsets answer with an error
		bQ.push_back((a > REG_STATUS || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY);
		awAddr <= a;
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bValid) break;
		end
		bReady <= 1'b0;
		if (n == 50) hang();
	endtask
	task automatic rd(input logic [4:0] a, input logic ck, input logic [33:0] exp,
		output logic [31:0] v);
		int n;
		@(posedge ref_clk);
		if (ck) rdQ.push_back(exp);
		rdChk <= ck;
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (arValid && arReady) arValid <= 1'b0;
			if (rValid) break;
		end
		v = rData;
		rReady <= 1'b0;
		if (n == 50) hang();
	endtask
	task automatic xfer(input logic [31:0] ctl, input logic [33:0] st);
		int n;
		wr(REG_CTRL, ctl);
		d = 32'h0;
		for (n = 0; n < 3000 && !d[STAT_DONE]; n++) rd(REG_STATUS, 1'b0, 34'h0, d);
		if (!d[STAT_DONE]) hang();
		rd(REG_STATUS, 1'b1, st, d);
		wr(REG_STATUS, 32'h3);
	endtask

	always @(posedge ref_clk) begin
		if (rValid && rReady && rdChk && rdQ.size() > 0) begin
			chk("read", {rResp, rData}, rdQ.pop_front());
		end
		if (dacPulse && dacQ.size() > 0) begin
			chk("dac", {23'h0, top, code}, {23'h0, dacQ.pop_front()});
		end else if (dacPulse) begin
			chk("extra load", 34'h1, 34'h0);
		end
		if (bValid && bReady && bQ.size() > 0) begin
			chk("bresp", 34'(bResp), 34'(bQ.pop_front()));
		end
		if (addr) addrCnt++;
		if (clrPulse) clrCnt++;
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(REG_SLAVE, 1'b1, 34'h0C, d);
		chk("code", 34'(code), 34'h0);
		seed = 32'h09E7;
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			w = seed[15:0];
			wr(REG_SLAVE, 32'h0C + i);
			wr(REG_WDATA, {16'h0, w});
			dacQ.push_back({w[15], w[13:4]});
			xfer(32'h1, 34'h1);
			chk("inreg", 34'(inReg), 34'(w));
			chk("pwrdn", 34'(pwrDn), 34'(w[15]));
			// The first three words leave the soft bit clear, so there the pin alone must act; the fourth sets it
			pinN <= 1'b0;
			repeat (2) @(posedge ref_clk);
			chk("pin", 34'(pwrDn), 34'h1);
			pinN <= 1'b1;
		end
		chk("addressed", 34'(addrCnt > 0), 34'h1);
		chk("no clear", 34'(clrCnt), 34'h0);
		xfer(32'h2, 34'h1);
		rd(REG_RDATA, 1'b1, 34'(w), d);
		chk("clear", 34'(inReg), 34'h0);
		chk("clear pulse", 34'(clrCnt), 34'h1);
		chk("hold", 34'(code), 34'(w[13:4]));
		wr(REG_SLAVE, 32'h10);
		mark = addrCnt;
		xfer(32'h1, 34'h3);
		chk("not addressed", 34'(addrCnt - mark), 34'h0);
		wr(5'h14, 32'h0);
		rd(5'h14, 1'b1, {RESP_SLVERR, 32'h0}, d);
		chk("loads", 34'(dacQ.size()), 34'h0);
		give_verdict();
	end
endmodule

/* verilog/icd_device.sv */
// Purpose: Serial slave end of the current-sink converter control port.
// Assumes: scl and sda arrive unsynchronised; ref_clk far above bus rate.
// Notes: Power-down output is combinational so the pin acts without clock.
`timescale 1ns/1ps
module icd_device (
	input  logic                      ref_clk,
	input  logic                      rst,
	icd_link_if.device                link,
	input  logic                      powerOffControlN,
	output logic [icd_pkg::CODE_W-1:0] converterCodeBits,
	output logic                      inputBitTop,
	output logic [15:0]               inputRegValue,
	output logic                      powerDown,
	output logic                      addressed,
	output logic                      dacLoadPulse,
	output logic                      readClearPulse
);
	import icd_pkg::*;

	typedef enum logic [2:0] {
		D_IDLE,
		D_ADDR,
		D_ACK,
		D_WRITE,
		D_READ,
		D_RD_ACK,
		D_IGNORE
	} icd_dev_state_t;

	icd_dev_state_t state_q;
	logic [1:0]     lineS;
	logic           sclS;
	logic           sdaS;
	logic           sclP_q;
	logic           sdaP_q;
	logic           sclRise;
	logic           sclFall;
	logic           startCond;
	logic           stopCond;
	logic [2:0]     bitCnt_q;
	logic [7:0]     rx_q;
	logic [7:0]     rxByte;
	logic [7:0]     tx_q;
	logic           rw_q;
	logic           curLow_q;
	logic           ackOn_q;
	logic           masterAck_q;
	logic           sdaOe_q;
	logic           addrHit;
	logic           wrByteEnd;
	logic           rdDone;
	logic [15:0]    inReg_q;
	logic [15:0]    dacReg_q;
	logic           loadPulse_q;
	logic           clearPulse_q;

	// ------------------------------------------------------------
	// Line sampling and framing
	// ------------------------------------------------------------
	icd_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'h3)
	) uLineSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.din     ({link.scl, link.sda}),
		.dout    (lineS)
	);

	assign sclS = lineS[1];
	assign sdaS = lineS[0];

	// Over 600 cycles per bus bit at fast mode, so edges are never missed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
		end else begin
			sclP_q <= sclS;
			sdaP_q <= sdaS;
		end
	end

	assign sclRise   = sclS && !sclP_q;
	assign sclFall   = !sclS && sclP_q;
	// Sda moves with scl high only at framing, data moves with scl low
	assign startCond = sclS && sclP_q && sdaP_q && !sdaS;
	assign stopCond  = sclS && sclP_q && !sdaP_q && sdaS;

	assign rxByte    = {rx_q[6:0], sdaS};
	assign addrHit   = (rxByte[7:3] == ADDR_PREFIX);
	assign wrByteEnd = (state_q == D_WRITE) && sclRise && (bitCnt_q == BIT_LAST);
	assign rdDone    = (state_q == D_RD_ACK) && sclRise && ackOn_q && curLow_q;

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q     <= D_IDLE;
			bitCnt_q    <= 3'h0;
			rx_q        <= 8'h00;
			rw_q        <= 1'b0;
			curLow_q    <= 1'b0;
			ackOn_q     <= 1'b0;
			masterAck_q <= 1'b0;
		end else if (startCond) begin
			// Repeated start also lands here
			state_q  <= D_ADDR;
			bitCnt_q <= 3'h0;
			ackOn_q  <= 1'b0;
		end else if (stopCond) begin
			state_q <= D_IDLE;
		end else if (sclRise) begin
			bitCnt_q <= bitCnt_q + 3'h1;
			case (state_q)
				D_ADDR: begin
					rx_q <= rxByte;
					if (bitCnt_q == BIT_LAST) begin
						state_q  <= addrHit ? D_ACK : D_IGNORE;
						rw_q     <= sdaS;
						curLow_q <= 1'b1;
						ackOn_q  <= 1'b0;
					end
				end
				D_WRITE: begin
					rx_q <= rxByte;
					if (bitCnt_q == BIT_LAST) begin
						state_q <= D_ACK;
						ackOn_q <= 1'b0;
					end
				end
				D_READ: begin
					if (bitCnt_q == BIT_LAST) begin
						state_q <= D_RD_ACK;
						ackOn_q <= 1'b0;
					end
				end
				D_RD_ACK: begin
					if (ackOn_q) begin
						masterAck_q <= !sdaS;
					end
				end
				default: begin
				end
			endcase
		end else if (sclFall) begin
			case (state_q)
				D_ACK: begin
					if (!ackOn_q) begin
						ackOn_q <= 1'b1;
					end else begin
						state_q  <= rw_q ? D_READ : D_WRITE;
						bitCnt_q <= 3'h0;
						// Bytes pair high then low; extra bytes start a new pair
						curLow_q <= !curLow_q;
					end
				end
				D_RD_ACK: begin
					if (!ackOn_q) begin
						ackOn_q <= 1'b1;
					end else if (masterAck_q && !curLow_q) begin
						state_q  <= D_READ;
						bitCnt_q <= 3'h0;
						curLow_q <= 1'b1;
					end else begin
						state_q <= D_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Input and converter registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			inReg_q  <= INREG_RESET;
			dacReg_q <= INREG_RESET;
		end else if (wrByteEnd && !curLow_q) begin
			inReg_q[15:8] <= rxByte;
		end else if (wrByteEnd) begin
			inReg_q[7:0] <= rxByte;
			dacReg_q     <= {inReg_q[15:8], rxByte};
		end else if (rdDone) begin
			inReg_q <= INREG_RESET;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			loadPulse_q  <= 1'b0;
			clearPulse_q <= 1'b0;
		end else begin
			loadPulse_q  <= wrByteEnd && curLow_q;
			clearPulse_q <= rdDone;
		end
	end

	// ------------------------------------------------------------
	// Data line driver
	// ------------------------------------------------------------
	// Changes only after scl falls, except the clear at start and stop, so sda is stable over every data high phase
	always_ff @(posedge ref_clk) begin
		if (rst || startCond || stopCond) begin
			sdaOe_q <= 1'b0;
			tx_q    <= 8'h00;
		end else if (sclFall) begin
			case (state_q)
				D_ACK: begin
					if (!ackOn_q) begin
						sdaOe_q <= 1'b1;
					end else if (rw_q) begin
						sdaOe_q <= !inReg_q[15];
						tx_q    <= {inReg_q[14:8], 1'b0};
					end else begin
						sdaOe_q <= 1'b0;
					end
				end
				D_READ: begin
					sdaOe_q <= !tx_q[7];
					tx_q    <= {tx_q[6:0], 1'b0};
				end
				D_RD_ACK: begin
					if (ackOn_q && masterAck_q && !curLow_q) begin
						sdaOe_q <= !inReg_q[7];
						tx_q    <= {inReg_q[6:0], 1'b0};
					end else begin
						sdaOe_q <= 1'b0;
					end
				end
				default: begin
					sdaOe_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.devSdaOut    = 1'b0;
	assign link.devSdaOe     = sdaOe_q;
	assign converterCodeBits = dacReg_q[CODE_MSB:CODE_LSB];
	assign inputBitTop       = inReg_q[PWR_BIT];
	assign inputRegValue     = inReg_q;
	// Pin path has no flop: it must act with the bus clock stopped
	assign powerDown         = dacReg_q[PWR_BIT] || !powerOffControlN;
	assign addressed         = (state_q != D_IDLE) && (state_q != D_IGNORE)
	                           && (state_q != D_ADDR);
	assign dacLoadPulse      = loadPulse_q;
	assign readClearPulse    = clearPulse_q;
endmodule

/* verilog/icd_host.sv */
// Purpose: Bus master controller driving the converter port.
// Assumes: Software issues one transfer at a time over AXI4-Lite.
// Notes: No clock stretching support; the slave never stretches.
`timescale 1ns/1ps
module icd_host #(
	parameter int QUARTER_CYC = icd_pkg::SCL_QUARTER_CYC
)(
	input  logic                      ref_clk,
	input  logic                      rst,
	input  logic [icd_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  logic                      s_axi_awvalid,
	output logic                      s_axi_awready,
	input  logic [31:0]               s_axi_wdata,
	input  logic [3:0]                s_axi_wstrb,
	input  logic                      s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  logic                      s_axi_bready,
	input  logic [icd_pkg::AXI_AW-1:0] s_axi_araddr,
	input  logic                      s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  logic                      s_axi_rready,
	icd_link_if.host                  link
);
	import icd_pkg::*;

	localparam int QW = $clog2(QUARTER_CYC + 1);

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} icd_host_state_t;

	icd_host_state_t   state_q;
	logic              awHeld_q;
	logic              wHeld_q;
	logic [AXI_AW-1:0] awAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic [31:0]       readMux;
	logic              doWrite;
	logic              goWrite;
	logic              goRead;
	logic              clrStat;
	logic              finish;
	logic [6:0]        slvAddr_q;
	logic [15:0]       wrData_q;
	logic [15:0]       rdData_q;
	logic              done_q;
	logic              nack_q;
	logic [QW-1:0]     qCnt_q;
	logic              tick;
	logic [1:0]        phase_q;
	logic [3:0]        bitIdx_q;
	logic [1:0]        byteIdx_q;
	logic [7:0]        tx_q;
	logic [15:0]       rx_q;
	logic              readMode_q;
	logic              abort_q;
	logic              sclOe_q;
	logic              sdaOe_q;
	logic              sdaS;
	logic              rxData;
	logic              hostDrives;
	logic              hostAck;

	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		mapped = (a == REG_CTRL) || (a == REG_SLAVE) || (a == REG_WDATA)
		         || (a == REG_RDATA) || (a == REG_STATUS);
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready  = !wHeld_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign doWrite       = awHeld_q && wHeld_q;

	always_comb begin
		readMux = 32'h0000_0000;
		case (s_axi_araddr)
			REG_SLAVE:  readMux[6:0]  = slvAddr_q;
			REG_WDATA:  readMux[15:0] = wrData_q;
			REG_RDATA:  readMux[15:0] = rdData_q;
			REG_STATUS: begin
				readMux[STAT_DONE] = done_q;
				readMux[STAT_NACK] = nack_q;
				readMux[STAT_BUSY] = (state_q != H_IDLE);
			end
			default:    readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= readMux;
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control and status registers
	// ------------------------------------------------------------
	// Commands while busy are dropped
	assign goWrite = doWrite && (awAddr_q == REG_CTRL) && wStrb_q[0]
	                 && (state_q == H_IDLE) && wData_q[CTRL_WR_BIT] && !wData_q[CTRL_RD_BIT];
	assign goRead  = doWrite && (awAddr_q == REG_CTRL) && wStrb_q[0]
	                 && (state_q == H_IDLE) && wData_q[CTRL_RD_BIT];
	assign clrStat = doWrite && (awAddr_q == REG_STATUS) && wStrb_q[0];
	assign finish  = tick && (state_q == H_STOP) && (phase_q == 2'h3);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slvAddr_q <= ADDR_DEFAULT;
			wrData_q  <= 16'h0000;
		end else if (doWrite) begin
			if (awAddr_q == REG_SLAVE && wStrb_q[0])
				slvAddr_q <= wData_q[6:0];
			if (awAddr_q == REG_WDATA && wStrb_q[0])
				wrData_q[7:0] <= wData_q[7:0];
			if (awAddr_q == REG_WDATA && wStrb_q[1])
				wrData_q[15:8] <= wData_q[15:8];
		end
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_q   <= 1'b0;
			nack_q   <= 1'b0;
			rdData_q <= 16'h0000;
		end else begin
			if (finish)
				done_q <= 1'b1;
			else if (clrStat && wData_q[STAT_DONE])
				done_q <= 1'b0;
			if (finish && abort_q)
				nack_q <= 1'b1;
			else if (clrStat && wData_q[STAT_NACK])
				nack_q <= 1'b0;
			if (finish && readMode_q && !abort_q)
				rdData_q <= rx_q;
		end
	end

	// ------------------------------------------------------------
	// Bit engine
	// ------------------------------------------------------------
	icd_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'h1)
	) uSdaSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.din     (link.sda),
		.dout    (sdaS)
	);

	// Quarter-period enable keeps scl at or under fast-mode rate
	always_ff @(posedge ref_clk) begin
		if (rst || state_q == H_IDLE || qCnt_q == '0)
			qCnt_q <= QW'(QUARTER_CYC - 1);
		else
			qCnt_q <= qCnt_q - 1'b1;
	end

	assign tick       = (state_q != H_IDLE) && (qCnt_q == '0);
	assign rxData     = readMode_q && (byteIdx_q != 2'h0);
	assign hostDrives = (bitIdx_q != BIT_ACK) && !rxData;
	assign hostAck    = (bitIdx_q == BIT_ACK) && rxData && (byteIdx_q != LAST_BYTE);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q    <= H_IDLE;
			phase_q    <= 2'h0;
			bitIdx_q   <= 4'h0;
			byteIdx_q  <= 2'h0;
			tx_q       <= 8'h00;
			rx_q       <= 16'h0000;
			readMode_q <= 1'b0;
			abort_q    <= 1'b0;
			sclOe_q    <= 1'b0;
			sdaOe_q    <= 1'b0;
		end else if (state_q == H_IDLE) begin
			if (goWrite || goRead) begin
				state_q    <= H_START;
				phase_q    <= 2'h0;
				readMode_q <= goRead;
				tx_q       <= {slvAddr_q, goRead};
				byteIdx_q  <= 2'h0;
				bitIdx_q   <= 4'h0;
				abort_q    <= 1'b0;
			end
		end else if (tick) begin
			phase_q <= phase_q + 2'h1;
			case (state_q)
				H_START: begin
					if (phase_q == 2'h0) begin
						sdaOe_q <= 1'b1;
					end else begin
						sclOe_q <= 1'b1;
						state_q <= H_BIT;
						phase_q <= 2'h0;
					end
				end
				H_BIT: begin
					case (phase_q)
						2'h0: sdaOe_q <= hostDrives ? !tx_q[7] : hostAck;
						2'h1: sclOe_q <= 1'b0;
						2'h2: begin
							if (bitIdx_q == BIT_ACK && !rxData && sdaS)
								abort_q <= 1'b1;
							else if (bitIdx_q != BIT_ACK && rxData)
								rx_q <= {rx_q[14:0], sdaS};
						end
						default: begin
							sclOe_q <= 1'b1;
							if (bitIdx_q != BIT_ACK) begin
								bitIdx_q <= bitIdx_q + 4'h1;
								tx_q     <= {tx_q[6:0], 1'b0};
							end else if (abort_q || byteIdx_q == LAST_BYTE) begin
								state_q <= H_STOP;
							end else begin
								byteIdx_q <= byteIdx_q + 2'h1;
								bitIdx_q  <= 4'h0;
								tx_q      <= (byteIdx_q == 2'h0) ? wrData_q[15:8] : wrData_q[7:0];
							end
						end
					endcase
				end
				H_STOP: begin
					case (phase_q)
						2'h0: sdaOe_q <= 1'b1;
						2'h1: sclOe_q <= 1'b0;
						2'h2: sdaOe_q <= 1'b0;
						default: state_q <= H_IDLE;
					endcase
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	assign link.hostSclOut = 1'b0;
	assign link.hostSclOe  = sclOe_q;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSdaOe  = sdaOe_q;
endmodule

/* verilog/icd_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous line inputs.
// Assumes: Inputs are levels, slow against ref_clk.
// Notes: First stage is read only by the second.
`timescale 1ns/1ps
module icd_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
)(
	input  logic             ref_clk,
	input  logic             rst,
	input  logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= RESET_VAL;
			dout   <= RESET_VAL;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule
